/* hdl/cbae_pkg.sv */
// Purpose: Shared constants and types for the conditional branch alias unit
// Assumes: 16-bit byte-addressed program counter, opcode byte on bits 0..7
// Notes: Opcode layout 1 1 0 m m c c c, m = addressing mode, c = condition
package cbae_pkg;

    localparam int CBAE_PC_W = 16;
    localparam logic [15:0] CBAE_PC_RST = 16'h0000;
    localparam logic [15:0] CBAE_PC_STEP = 16'h0002;

    // ==========================================================
    // Opcode fields
    localparam logic [2:0] CBAE_OP_CLASS = 3'h6;
    localparam int CBAE_CLASS_HI = 7;
    localparam int CBAE_CLASS_LO = 5;
    localparam int CBAE_MODE_HI = 4;
    localparam int CBAE_MODE_LO = 3;
    localparam int CBAE_COND_HI = 2;
    localparam int CBAE_COND_LO = 0;

    // Condition codes of the base branches
    localparam logic [2:0] CBAE_COND_CSET = 3'h0;
    localparam logic [2:0] CBAE_COND_OSET = 3'h2;
    localparam logic [2:0] CBAE_COND_CCLR = 3'h3;
    localparam logic [2:0] CBAE_COND_OCLR = 3'h6;

    typedef enum logic [1:0] {
        CBAE_RELATIVE_PLUS_MODE,
        CBAE_RELATIVE_MINUS_MODE,
        CBAE_INDIRECT_LOCAL_MODE,
        CBAE_INDIRECT_GENERAL_MODE
    } cbae_mode_t;

    typedef enum logic [2:0] {
        CBAE_NONE,
        CBAE_BRANCH_ON_CARRY_SET,
        CBAE_BRANCH_ON_CARRY_CLEAR,
        CBAE_BRANCH_ON_OVERFLOW_SET,
        CBAE_BRANCH_ON_OVERFLOW_CLEAR
    } cbae_kind_t;

    typedef struct packed {
        logic carry;
        logic overflow;
    } cbae_flags_t;

    typedef struct packed {
        logic valid;
        cbae_kind_t kind;
        cbae_mode_t mode;
    } cbae_dec_t;

endpackage : cbae_pkg

/* hdl/cbae_decode.sv */
// Purpose: Decode an opcode byte into a conditional branch kind
// Assumes: Opcode byte presented in the same cycle as the strobe
// Notes: Aliases share encodings with their base branches
`timescale 1ns/1ps
module cbae_decode
    import cbae_pkg::*;
(
    input wire logic [7:0] opcode_i,
    output cbae_dec_t dec_o
);

    always_comb begin
        dec_o.valid = 1'b0;
        dec_o.kind = CBAE_NONE;
        dec_o.mode = cbae_mode_t'(opcode_i[CBAE_MODE_HI:CBAE_MODE_LO]);
        if (opcode_i[CBAE_CLASS_HI:CBAE_CLASS_LO] == CBAE_OP_CLASS) begin
            case (opcode_i[CBAE_COND_HI:CBAE_COND_LO])
                CBAE_COND_CSET: dec_o.kind = CBAE_BRANCH_ON_CARRY_SET;
                CBAE_COND_OSET: dec_o.kind = CBAE_BRANCH_ON_OVERFLOW_SET;
                CBAE_COND_CCLR: dec_o.kind = CBAE_BRANCH_ON_CARRY_CLEAR;
                CBAE_COND_OCLR: dec_o.kind = CBAE_BRANCH_ON_OVERFLOW_CLEAR;
                default: dec_o.kind = CBAE_NONE;
            endcase
            dec_o.valid = (dec_o.kind != CBAE_NONE);
        end
    end

endmodule : cbae_decode

/* hdl/cbae_cond.sv */
// Purpose: Evaluate the branch condition from carry and overflow
// Assumes: Flags are those left by the preceding load or compare
// Notes: Purely combinational, flags are only read
`timescale 1ns/1ps
module cbae_cond
    import cbae_pkg::*;
(
    input cbae_dec_t dec_i,
    input cbae_flags_t flags_i,
    output logic take_o
);

    always_comb begin
        case (dec_i.kind)
            CBAE_BRANCH_ON_CARRY_SET: take_o = flags_i.carry;
            CBAE_BRANCH_ON_CARRY_CLEAR: take_o = ~flags_i.carry;
            CBAE_BRANCH_ON_OVERFLOW_SET: take_o = flags_i.overflow;
            CBAE_BRANCH_ON_OVERFLOW_CLEAR: take_o = ~flags_i.overflow;
            default: take_o = 1'b0;
        endcase
    end

endmodule : cbae_cond

/* hdl/cbae_exec.sv */
// Purpose: Execute conditional branch aliases on the program counter
// Assumes: Effective address computed elsewhere and valid with exec_i
// Notes: Only the program counter changes; flags pass through untouched
`timescale 1ns/1ps

// Function
// - Zero alias after a load jumps to the target when carry is 1.
// - Zero alias with carry 0 advances the program counter by 2.
// - Less alias (C2, CA, D2, DA) jumps to the target when overflow is 1.
// - Less alias with overflow 0 continues at program counter plus 2.
// - Negative alias after a load jumps to the target when overflow is 1.
// - Negative alias with overflow 0 advances the program counter by 2.
// - Unequal alias (C3, CB, D3, DB) jumps to the target when carry is 0.
// - Unequal alias with carry 1 advances the program counter by 2.
// - Nonzero alias, sharing the unequal encodings, jumps when carry is 0.
// - Nonzero alias with carry 1 advances the program counter by 2.
// - Not-less alias jumps to the target when overflow is 0.
// - Not-less alias with overflow 1 continues at program counter plus 2.
// - Nonnegative alias jumps to the target when overflow is 0.
// - Nonnegative alias with overflow 1 advances the program counter by 2.
module cbae_exec
    import cbae_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic exec_i,
    input wire logic [7:0] opcode_i,
    input wire logic [15:0] eff_addr_i,
    input cbae_flags_t flags_i,
    output logic [15:0] pc_o,
    output cbae_flags_t flags_o,
    output logic done_o,
    output logic taken_o,
    output logic illegal_o
);

    // ==========================================================
    // Decode and condition
    cbae_dec_t dec;
    logic take;

    cbae_decode u_decode (
        .opcode_i(opcode_i),
        .dec_o(dec)
    );

    cbae_cond u_cond (
        .dec_i(dec),
        .flags_i(flags_i),
        .take_o(take)
    );

    // ==========================================================
    // Program counter state
    logic [15:0] pc_r;
    logic [15:0] pc_nxt;
    logic done_r;
    logic done_nxt;
    logic taken_r;
    logic taken_nxt;
    logic illegal_r;
    logic illegal_nxt;

    always_comb begin
        pc_nxt = pc_r;
        done_nxt = 1'b0;
        taken_nxt = 1'b0;
        illegal_nxt = 1'b0;
        if (exec_i) begin
            if (dec.valid) begin
                done_nxt = 1'b1;
                taken_nxt = take;
                if (take) begin
                    pc_nxt = eff_addr_i;
                end else begin
                    pc_nxt = pc_r + CBAE_PC_STEP;
                end
            end else begin
                illegal_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pc_r <= CBAE_PC_RST;
            done_r <= 1'b0;
            taken_r <= 1'b0;
            illegal_r <= 1'b0;
        end else begin
            pc_r <= pc_nxt;
            done_r <= done_nxt;
            taken_r <= taken_nxt;
            illegal_r <= illegal_nxt;
        end
    end

    assign pc_o = pc_r;
    assign done_o = done_r;
    assign taken_o = taken_r;
    assign illegal_o = illegal_r;
    // Flags pass unchanged
    assign flags_o = flags_i;

    // ==========================================================
    // Checks
    carry_set_jump_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        exec_i && opcode_i[2:0] == 3'h0 && opcode_i[7:5] == 3'h6 && flags_i.carry
        |=> pc_o == $past(eff_addr_i) && taken_o)
        else $error("carry set branch did not jump");

    carry_set_step_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        exec_i && opcode_i[2:0] == 3'h0 && opcode_i[7:5] == 3'h6 && !flags_i.carry
        |=> pc_o == $past(pc_o) + 16'h0002 && !taken_o)
        else $error("carry set branch did not step");

    ovf_set_jump_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        exec_i && opcode_i[2:0] == 3'h2 && opcode_i[7:5] == 3'h6 && flags_i.overflow
        |=> pc_o == $past(eff_addr_i))
        else $error("overflow set branch did not jump");

    ovf_set_step_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        exec_i && opcode_i[2:0] == 3'h2 && opcode_i[7:5] == 3'h6 && !flags_i.overflow
        |=> pc_o == $past(pc_o) + 16'h0002)
        else $error("overflow set branch did not step");

    carry_clr_jump_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        exec_i && opcode_i[2:0] == 3'h3 && opcode_i[7:5] == 3'h6 && !flags_i.carry
        |=> pc_o == $past(eff_addr_i))
        else $error("carry clear branch did not jump");

    carry_clr_step_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        exec_i && opcode_i[2:0] == 3'h3 && opcode_i[7:5] == 3'h6 && flags_i.carry
        |=> pc_o == $past(pc_o) + 16'h0002)
        else $error("carry clear branch did not step");

    ovf_clr_jump_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        exec_i && opcode_i[2:0] == 3'h6 && opcode_i[7:5] == 3'h6 && !flags_i.overflow
        |=> pc_o == $past(eff_addr_i))
        else $error("overflow clear branch did not jump");

    ovf_clr_step_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        exec_i && opcode_i[2:0] == 3'h6 && opcode_i[7:5] == 3'h6 && flags_i.overflow
        |=> pc_o == $past(pc_o) + 16'h0002)
        else $error("overflow clear branch did not step");

    // Reset edges excluded, the counter reloads there
    pc_hold_idle_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        !srst_i && (!exec_i || illegal_nxt) |=> $stable(pc_o) && !done_o)
        else $error("program counter moved without a branch");

    // ==========================================================
    // Checks by literal opcode
    zero_alias_jump_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        exec_i && opcode_i inside {8'hC0, 8'hC8, 8'hD0, 8'hD8} && flags_i.carry
        |=> pc_o == $past(eff_addr_i) && taken_o && done_o)
        else $error("zero alias did not jump");

    zero_alias_step_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        exec_i && opcode_i inside {8'hC0, 8'hC8, 8'hD0, 8'hD8} && !flags_i.carry
        |=> pc_o == $past(pc_o) + CBAE_PC_STEP && !taken_o && done_o)
        else $error("zero alias did not step");

    less_alias_jump_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        exec_i && opcode_i inside {8'hC2, 8'hCA, 8'hD2, 8'hDA} && flags_i.overflow
        |=> pc_o == $past(eff_addr_i) && taken_o && done_o)
        else $error("less alias did not jump");

    less_alias_step_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        exec_i && opcode_i inside {8'hC2, 8'hCA, 8'hD2, 8'hDA} && !flags_i.overflow
        |=> pc_o == $past(pc_o) + CBAE_PC_STEP && !taken_o && done_o)
        else $error("less alias did not step");

    unequal_alias_jump_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        exec_i && opcode_i inside {8'hC3, 8'hCB, 8'hD3, 8'hDB} && !flags_i.carry
        |=> pc_o == $past(eff_addr_i) && taken_o && done_o)
        else $error("unequal alias did not jump");

    unequal_alias_step_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        exec_i && opcode_i inside {8'hC3, 8'hCB, 8'hD3, 8'hDB} && flags_i.carry
        |=> pc_o == $past(pc_o) + CBAE_PC_STEP && !taken_o && done_o)
        else $error("unequal alias did not step");

    not_less_jump_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        exec_i && opcode_i inside {8'hC6, 8'hCE, 8'hD6, 8'hDE} && !flags_i.overflow
        |=> pc_o == $past(eff_addr_i) && taken_o && done_o)
        else $error("not-less alias did not jump");

    not_less_step_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        exec_i && opcode_i inside {8'hC6, 8'hCE, 8'hD6, 8'hDE} && flags_i.overflow
        |=> pc_o == $past(pc_o) + CBAE_PC_STEP && !taken_o && done_o)
        else $error("not-less alias did not step");

    // ==========================================================
    // Result pulse checks
    valid_decode_done_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        exec_i && opcode_i inside {8'hC0, 8'hC8, 8'hD0, 8'hD8, 8'hC2, 8'hCA, 8'hD2, 8'hDA,
            8'hC3, 8'hCB, 8'hD3, 8'hDB, 8'hC6, 8'hCE, 8'hD6, 8'hDE}
        |=> done_o && !illegal_o)
        else $error("decoded alias gave no done pulse");

    class_other_illegal_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        exec_i && opcode_i[CBAE_CLASS_HI:CBAE_CLASS_LO] == CBAE_OP_CLASS
            && !(opcode_i[CBAE_COND_HI:CBAE_COND_LO] inside {3'h0, 3'h2, 3'h3, 3'h6})
        |=> illegal_o && !done_o && !taken_o && $stable(pc_o))
        else $error("undecoded condition was not refused");

    foreign_class_illegal_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        exec_i && opcode_i[CBAE_CLASS_HI:CBAE_CLASS_LO] != CBAE_OP_CLASS
        |=> illegal_o && !done_o && !taken_o && $stable(pc_o))
        else $error("foreign opcode was not refused");

    idle_no_pulse_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        !srst_i && !exec_i
        |=> !done_o && !taken_o && !illegal_o)
        else $error("result pulse without an execute");

    taken_with_done_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        taken_o
        |-> done_o)
        else $error("taken pulse without done pulse");

    done_not_illegal_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        done_o
        |-> !illegal_o)
        else $error("done and illegal pulses together");

    jump_pc_target_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        done_o && taken_o
        |-> pc_o == $past(eff_addr_i))
        else $error("taken branch missed its target");

    step_pc_next_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        done_o && !taken_o
        |-> pc_o == $past(pc_o) + CBAE_PC_STEP)
        else $error("untaken branch did not step");

    illegal_pc_hold_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        illegal_o
        |-> $stable(pc_o))
        else $error("refused opcode moved the program counter");

    pc_moves_done_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        !done_o && !$past(srst_i)
        |-> $stable(pc_o))
        else $error("program counter moved without done pulse");

    done_after_exec_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        done_o
        |-> $past(exec_i))
        else $error("done pulse without an execute");

    illegal_after_exec_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        illegal_o
        |-> $past(exec_i))
        else $error("illegal pulse without an execute");

    // ==========================================================
    // Reset checks
    reset_clears_a: assert property (
        @(posedge ref_clk_i)
        srst_i
        |=> pc_o == CBAE_PC_RST && !done_o && !taken_o && !illegal_o)
        else $error("reset did not clear the results");

    reset_release_idle_a: assert property (
        @(posedge ref_clk_i)
        $past(srst_i) && !srst_i
        |-> pc_o == CBAE_PC_RST && !done_o && !illegal_o)
        else $error("results not idle after reset release");

endmodule : cbae_exec

/* testbench/tb_top.sv */
// Purpose: Self-checking bench for the conditional branch alias unit
// Assumes: Results are registered one cycle after the execute strobe
// Notes: Reset check first, then table rows, illegal, wrap, back-to-back and mid-run reset cases
`timescale 1ns/1ps
module tb_top
    import cbae_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic exec_i = 1'b0;
    logic [7:0] opcode_i = 8'h00;
    logic [15:0] eff_addr_i = 16'h0000;
    cbae_flags_t flags_i = '0;
    logic [15:0] pc_o;
    cbae_flags_t flags_o;
    logic done_o;
    logic taken_o;
    logic illegal_o;
    int mismatches = 0;
    int check_count = 0;
    logic [15:0] exp_pc = 16'h0000;
    // Rows: opcode, carry, overflow, expected jump
    localparam logic [10:0] ROWS [16] = '{
        {8'hC0, 3'h5}, {8'hC8, 3'h0}, {8'hD2, 3'h3}, {8'hDA, 3'h0},
        {8'hC2, 3'h3}, {8'hCA, 3'h4}, {8'hC3, 3'h1}, {8'hCB, 3'h4},
        {8'hD3, 3'h3}, {8'hDB, 3'h6}, {8'hC6, 3'h1}, {8'hCE, 3'h2},
        {8'hD6, 3'h5}, {8'hDE, 3'h6}, {8'hD0, 3'h7}, {8'hD8, 3'h2}};

    always #10 ref_clk_i = ~ref_clk_i;

    cbae_exec DUT (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .exec_i(exec_i),
        .opcode_i(opcode_i),
        .eff_addr_i(eff_addr_i),
        .flags_i(flags_i),
        .pc_o(pc_o),
        .flags_o(flags_o),
        .done_o(done_o),
        .taken_o(taken_o),
        .illegal_o(illegal_o)
    );

    // ==========================================================
    // Helpers
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic final_report();
        if (mismatches == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    // One execute pulse, then results checked one cycle later
    task automatic issue(input logic [7:0] op, input logic c, input logic o,
                         input logic [15:0] ea, input logic t, input logic ill);
        @(posedge ref_clk_i);
        exec_i <= 1'b1;
        opcode_i <= op;
        flags_i <= '{carry: c, overflow: o};
        eff_addr_i <= ea;
        #1;
        check("flags_o", 16'(flags_o), {14'h0000, c, o});
        @(posedge ref_clk_i);
        exec_i <= 1'b0;
        #1;
        if (!ill) begin
            exp_pc = t ? ea : exp_pc + 16'h0002;
        end
        check("pc_o", pc_o, exp_pc);
        check("taken_o", 16'(taken_o), 16'(t && !ill));
        check("done_o", 16'(done_o), 16'(!ill));
        check("illegal_o", 16'(illegal_o), 16'(ill));
    endtask : issue

    // ==========================================================
    // Watchdog
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        mismatches++;
        final_report();
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        #1;
        check("pc_o reset", pc_o, 16'h0000);
        check("done_o reset", 16'(done_o), 16'h0000);
        check("taken_o reset", 16'(taken_o), 16'h0000);
        check("illegal_o reset", 16'(illegal_o), 16'h0000);
        for (int i = 0; i < 16; i++) begin
            issue(ROWS[i][10:3], ROWS[i][2], ROWS[i][1], 16'h1000 + 16'(i * 260),
                  ROWS[i][0], 1'b0);
        end
        // Undecoded opcodes hold the program counter
        issue(8'hC1, 1'b1, 1'b1, 16'h5555, 1'b0, 1'b1);
        issue(8'h00, 1'b0, 1'b0, 16'h6666, 1'b0, 1'b1);
        // Wrap of the sequential step
        issue(8'hC0, 1'b1, 1'b0, 16'hFFFE, 1'b1, 1'b0);
        issue(8'hCB, 1'b1, 1'b0, 16'h2222, 1'b0, 1'b0);
        // Back-to-back executes
        @(posedge ref_clk_i);
        exec_i <= 1'b1;
        opcode_i <= 8'hC6;
        flags_i <= '{carry: 1'b0, overflow: 1'b0};
        eff_addr_i <= 16'hABCC;
        @(posedge ref_clk_i);
        opcode_i <= 8'hDE;
        flags_i <= '{carry: 1'b0, overflow: 1'b1};
        eff_addr_i <= 16'h1110;
        #1;
        check("pc_o b2b first", pc_o, 16'hABCC);
        check("taken_o b2b first", 16'(taken_o), 16'h0001);
        @(posedge ref_clk_i);
        exec_i <= 1'b0;
        #1;
        check("pc_o b2b second", pc_o, 16'hABCE);
        check("taken_o b2b second", 16'(taken_o), 16'h0000);
        @(posedge ref_clk_i);
        #1;
        check("done_o idle", 16'(done_o), 16'h0000);
        check("pc_o idle", pc_o, 16'hABCE);
        // Reset in mid-run
        @(posedge ref_clk_i);
        srst_i <= 1'b1;
        @(posedge ref_clk_i);
        srst_i <= 1'b0;
        #1;
        check("pc_o rereset", pc_o, 16'h0000);
        check("done_o rereset", 16'(done_o), 16'h0000);
        check("taken_o rereset", 16'(taken_o), 16'h0000);
        check("illegal_o rereset", 16'(illegal_o), 16'h0000);
        exp_pc = 16'h0000;
        issue(8'hDB, 1'b0, 1'b1, 16'h0F0E, 1'b1, 1'b0);
        final_report();
    end
endmodule : tb_top
